// ---- common/scd_pkg.sv ----
// ============================================================
// shared constants and types of the clock derivation block
// ============================================================
package scd_pkg;

  // ==========================================================
  // bus geometry and register byte offsets
  // ==========================================================
  localparam int          ADR_W          = 8;
  localparam int          DAT_W          = 32;
  localparam logic [7:0]  OFS_CFG_LOW    = 8'h00; // latched low config word
  localparam logic [7:0]  OFS_CFG_HIGH   = 8'h04; // latched high config word
  localparam logic [7:0]  OFS_SYS_RATIO  = 8'h08; // system side ratios
  localparam logic [7:0]  OFS_ENG_RATIO  = 8'h0C; // engine side ratios
  localparam logic [7:0]  OFS_UNIT_CTRL  = 8'h10; // unit clock control
  localparam logic [7:0]  OFS_LB_CTRL    = 8'h14; // local bus clock control
  localparam logic [7:0]  OFS_STATUS     = 8'h18; // block status
  localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;

  // ==========================================================
  // low reset configuration word layout
  // ==========================================================
  typedef struct packed {
    logic       localBusClockRatio;  // lb clock = sys * (1 + x)
    logic       memctlOneClockRatio; // memctl clock = sys * (1 + x)
    logic [1:0] spareA;
    logic [3:0] systemPllMultiplier;
    logic       spareB;
    logic [6:0] corePllRatio;        // core multiple in half steps
    logic [7:0] spareC;
    logic [1:0] engineVcoDivider;
    logic       enginePllDivider;
    logic [4:0] enginePllMultiplier;
  } scd_cfg_low_t;

  // high reset configuration word layout
  typedef struct packed {
    logic        hostModeSelect;
    logic        pciClockOutputEnable;
    logic [29:0] spare;
  } scd_cfg_high_t;

  // all pins that cross into the clock domain together
  typedef struct packed {
    logic          hardResetInput_b;
    logic          clkinDivider;
    logic [2:0]    resetSource;
    scd_cfg_high_t cfgHigh;
    scd_cfg_low_t  cfgLow;
  } scd_pins_t;

  // unit clock control register layout
  typedef struct packed {
    logic [28:0] spare;
    logic        pciDmaEnable;
    logic [1:0]  securityRatio;
  } scd_unit_ctrl_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b01,  // hard reset held, straps are inputs
    ST_RUN    = 2'b10   // straps latched, pins back to normal
  } scd_state_t;

  // ==========================================================
  // codes and reset values
  // ==========================================================
  localparam logic [1:0] SEC_OFF         = 2'h0;
  localparam logic [1:0] SEC_FULL        = 2'h1;
  localparam logic [1:0] SEC_THIRD       = 2'h3;
  localparam logic       PCI_RESET       = 1'b1;
  localparam int         DIV_W           = 4;
  localparam logic [3:0] LB_DIV_RESET    = 4'h2;
  localparam logic [3:0] MEM_BUS_DIV     = 4'h2;
  localparam logic [3:0] DIV_FULL        = 4'h1;
  localparam logic [3:0] DIV_OFF         = 4'h0;
  localparam logic [4:0] ENG_CODE_X16    = 5'h00;
  localparam logic [4:0] ENG_CODE_RSVD   = 5'h01;
  localparam logic [4:0] ENG_CODE_MAX    = 5'h1C;
  localparam logic [4:0] ENG_FACTOR_X16  = 5'h10;
  localparam logic [4:0] ENG_FACTOR_NONE = 5'h00;
  localparam logic [4:0] VCO_BASE        = 5'h02;
  localparam logic [2:0] SRC_EXTERNAL    = 3'h0;
  localparam logic [2:0] SRC_OPTION_A    = 3'h1;
  localparam logic [2:0] SRC_OPTION_B    = 3'h2;
  localparam logic [31:0] OPT_WORD_A     = 32'h0404_0004;
  localparam logic [31:0] OPT_WORD_B     = 32'h0603_0009;
  localparam logic [31:0] OPT_WORD_C     = 32'h4804_010C;

endpackage

// ---- design/scd_clk_div.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// glitch-free integer clock divider / clock enable
// ============================================================
module scd_clk_div #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] divisor,  // 0 stops the unit clock
  output logic              tick,     // one-cycle enable per period
  output logic              level     // divided clock waveform
);

  logic [W-1:0] count;      // position inside the current period
  logic [W-1:0] activeDiv;  // divisor of the period now running

  // ==========================================================
  // period counter
  // ==========================================================
  // a new divisor is taken only at the end of a whole period,
  // so a high phase is never cut short into a runt pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count     <= '0;
      activeDiv <= '0;
    end else if (ce) begin
      if (activeDiv == '0 || count == activeDiv - W'(1)) begin
        count     <= '0;
        activeDiv <= divisor;
      end else begin
        count <= count + W'(1);
      end
    end
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  // high for the first half period, rounded up for odd ratios
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick  <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      tick  <= (activeDiv != '0) && (count == '0);
      level <= (activeDiv != '0) && ({count, 1'b0} < {1'b0, activeDiv});
    end
  end

  chk_divisor_boundary: assert property (
    @(posedge clk) disable iff (!rst_b)
    (activeDiv != $past(activeDiv)) |->
      ($past(activeDiv) == '0 ||
       $past(count) == $past(activeDiv) - W'(1)))
    else $error("divisor changed inside a running period");

endmodule
`default_nettype wire

// ---- design/scd_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - host mode without clock drive uses sync input
// - system clock = input * (1+divider) * multiplier
// - core clock multiplies the system clock
// - multipliers come from low config word
// - engine clock = input * mult / (1+div)
// - engine PLL set only by three fields
// - engine code 0 is x16, 1 reserved
// - engine VCO = clock * vco * (1+div)
// - memctl clock scaled; bus clock halved
// - local bus clock scaled, outputs divided
// - unit clocks default, security at third
// - system and engine domains set independently
// - any valid pair of settings accepted
// - straps sampled in reset, latched at release
module scd_top
  import scd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // wishbone classic slave
  input  wire logic             wbCyc,
  input  wire logic             wbStb,
  input  wire logic             wbWe,
  input  wire logic [ADR_W-1:0] wbAdr,
  input  wire logic [3:0]       wbSel,
  input  wire logic [DAT_W-1:0] wbDatIn,
  output logic      [DAT_W-1:0] wbDatOut,
  output logic                  wbAck,
  // configuration pins, asynchronous to clk
  input  wire logic             hardResetInput_b,
  input  wire logic             clkinDividerPin,
  input  wire logic [2:0]       resetSourcePin,
  input  wire logic [31:0]      resetConfigWordLow,
  input  wire logic [31:0]      resetConfigWordHigh,
  // derived clock configuration
  output logic                  strapReceiverEnable,
  output logic                  configReady,
  output logic                  primaryFromPciSync,
  output logic                  agentStrapFault,
  output logic      [5:0]       sysBusMult,
  output logic      [10:0]      coreHalfMult,
  output logic      [4:0]       engineMult,
  output logic      [1:0]       engineDivide,
  output logic      [9:0]       engineVcoMult,
  output logic                  engineCodeReserved,
  output logic      [6:0]       memctlOneMult,
  output logic      [6:0]       localBusUnitMult,
  // unit clocks
  output logic                  memctlOneBusClock,
  output logic      [2:0]       localBusClockOutputs,
  output logic                  localBusSyncOutput,
  output logic                  securityClockEnable,
  output logic                  pciDmaClockEnable
);

  // ==========================================================
  // functions
  // ==========================================================
  // engine multiplier code to factor; reserved codes give none
  function automatic logic [4:0] engFactor(input logic [4:0] code);
    if (code == ENG_CODE_X16) begin
      return ENG_FACTOR_X16;
    end else if (code == ENG_CODE_RSVD || code > ENG_CODE_MAX) begin
      return ENG_FACTOR_NONE;
    end else begin
      return code;
    end
  endfunction

  // reserved engine multiplier code check
  function automatic logic engReserved(input logic [4:0] code);
    return (code == ENG_CODE_RSVD) || (code > ENG_CODE_MAX);
  endfunction

  // vco divider code to factor: 2, 4, 8, 16
  function automatic logic [4:0] vcoFactor(input logic [1:0] code);
    return VCO_BASE << code;
  endfunction

  // a "(1 + one-bit field)" ratio is a doubling or nothing
  function automatic logic [6:0] scaleOnePlus(input logic [5:0] base,
                                               input logic       bit1);
    return bit1 ? {base, 1'b0} : {1'b0, base};
  endfunction

  // system multiple straight from the latched fields, so that every
  // ratio built on it is valid in the cycle configReady rises
  function automatic logic [5:0] sysMultOf(input scd_cfg_low_t c,
                                           input logic         d);
    return 6'(scaleOnePlus(6'(c.systemPllMultiplier), d));
  endfunction

  // built-in reset word for each reset source strap except external, which passes the pin word
  function automatic logic [31:0] optionWord(input logic [2:0]  src,
                                             input logic [31:0] ext);
    if (src == SRC_EXTERNAL) begin
      return ext;
    end else if (src == SRC_OPTION_A) begin
      return OPT_WORD_A;
    end else if (src == SRC_OPTION_B) begin
      return OPT_WORD_B;
    end else begin
      return OPT_WORD_C;
    end
  endfunction

  // ==========================================================
  // declarations
  // ==========================================================
  scd_pins_t      pinMeta;          // first synchroniser stage
  scd_pins_t      pinSync;          // second synchroniser stage
  scd_state_t     state;            // strap capture state
  scd_cfg_low_t   cfgLow;           // latched low config word
  scd_cfg_high_t  cfgHigh;          // latched high config word
  logic           clkinDivLatched;  // latched input divider strap
  scd_unit_ctrl_t unitCtrl;         // software unit clock control
  logic [3:0]     lbOutDiv;         // local bus output divider
  logic           unitWritten;      // helper: unit ctrl ever written
  logic [31:0]    rdData;           // read mux result
  logic           busReq;           // request in progress
  logic           lbLevel;          // divided local bus clock
  logic [3:0]     secDivisor;       // security clock divisor

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  // straps are static during reset, so a plain two-stage sync
  // of the whole group is safe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else if (ce) begin
      pinMeta <= {hardResetInput_b, clkinDividerPin, resetSourcePin,
                  resetConfigWordHigh, resetConfigWordLow};
      pinSync <= pinMeta;
    end
  end

  // ==========================================================
  // strap capture
  // ==========================================================
  // receivers stay on only while hard reset is held; values are
  // kept at the release edge, and a new hard reset resamples
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state               <= ST_SAMPLE;
      cfgLow              <= '0;
      cfgHigh             <= '0;
      clkinDivLatched     <= 1'b0;
      strapReceiverEnable <= 1'b1;
    end else if (ce) begin
      case (state)
        ST_SAMPLE: begin
          if (pinSync.hardResetInput_b) begin
            state               <= ST_RUN;
            cfgLow              <= optionWord(pinSync.resetSource,
                                              pinSync.cfgLow);
            cfgHigh             <= pinSync.cfgHigh;
            clkinDivLatched     <= pinSync.clkinDivider;
            strapReceiverEnable <= 1'b0;
          end
        end
        ST_RUN: begin
          if (!pinSync.hardResetInput_b) begin
            state               <= ST_SAMPLE;
            strapReceiverEnable <= 1'b1;
          end
        end
        default: begin
          state <= ST_SAMPLE;
        end
      endcase
    end
  end

  // ==========================================================
  // system / core domain ratios
  // ==========================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      configReady        <= 1'b0;
      primaryFromPciSync <= 1'b0;
      agentStrapFault    <= 1'b0;
      sysBusMult         <= '0;
      coreHalfMult       <= '0;
      memctlOneMult      <= '0;
      localBusUnitMult   <= '0;
    end else if (ce) begin
      configReady        <= (state == ST_RUN);
      primaryFromPciSync <= cfgHigh.hostModeSelect &&
                            !cfgHigh.pciClockOutputEnable;
      // agent mode leans on the board grounding the divider strap
      agentStrapFault    <= !cfgHigh.hostModeSelect &&
                            clkinDivLatched;
      sysBusMult         <= sysMultOf(cfgLow, clkinDivLatched);
      // core PLL sits behind the system PLL: in half steps
      coreHalfMult       <= 11'(sysMultOf(cfgLow, clkinDivLatched)) *
                            11'(cfgLow.corePllRatio[4:0]);
      memctlOneMult      <= scaleOnePlus(sysMultOf(cfgLow, clkinDivLatched),
                              cfgLow.memctlOneClockRatio);
      localBusUnitMult   <= scaleOnePlus(sysMultOf(cfgLow, clkinDivLatched),
                              cfgLow.localBusClockRatio);
    end
  end

  // ==========================================================
  // engine domain ratios
  // ==========================================================
  // this domain reads only its own three fields, so any system
  // setting pairs with any engine setting on the common input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      engineMult         <= '0;
      engineDivide       <= '0;
      engineVcoMult      <= '0;
      engineCodeReserved <= 1'b0;
    end else if (ce) begin
      engineMult         <= engFactor(cfgLow.enginePllMultiplier);
      engineCodeReserved <= engReserved(cfgLow.enginePllMultiplier);
      engineDivide       <= 2'(scaleOnePlus(6'(DIV_FULL),
                              cfgLow.enginePllDivider));
      // vco = clock * vco * (1+div) = input * mult * vco
      engineVcoMult      <= 10'(engFactor(cfgLow.enginePllMultiplier)) *
                            10'(vcoFactor(cfgLow.engineVcoDivider));
    end
  end

  // ==========================================================
  // wishbone slave
  // ==========================================================
  assign busReq = wbCyc && wbStb;

  // read mux; unmapped addresses read as zero
  always_comb begin
    if (wbAdr == OFS_CFG_LOW) begin
      rdData = cfgLow;
    end else if (wbAdr == OFS_CFG_HIGH) begin
      rdData = cfgHigh;
    end else if (wbAdr == OFS_SYS_RATIO) begin
      rdData = {12'h000, localBusUnitMult, memctlOneMult, sysBusMult};
    end else if (wbAdr == OFS_ENG_RATIO) begin
      rdData = {14'h0000, engineCodeReserved, engineVcoMult,
                engineDivide, engineMult};
    end else if (wbAdr == OFS_UNIT_CTRL) begin
      rdData = unitCtrl;
    end else if (wbAdr == OFS_LB_CTRL) begin
      rdData = {28'h000_0000, lbOutDiv};
    end else if (wbAdr == OFS_STATUS) begin
      rdData = {29'h0000_0000, agentStrapFault, primaryFromPciSync,
                configReady};
    end else begin
      rdData = RD_UNMAPPED;
    end
  end

  // one wait state; ack falls in the cycle after it was given
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbAck    <= 1'b0;
      wbDatOut <= '0;
    end else if (ce) begin
      wbAck    <= busReq && !wbAck;
      wbDatOut <= rdData;
    end
  end

  // writes land on the edge where the master sees ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unitCtrl              <= '0;
      unitCtrl.securityRatio <= SEC_THIRD;
      unitCtrl.pciDmaEnable <= PCI_RESET;
      lbOutDiv              <= LB_DIV_RESET;
      unitWritten           <= 1'b0;
    end else if (ce && busReq && wbWe && wbAck && wbSel[0]) begin
      if (wbAdr == OFS_UNIT_CTRL) begin
        // full rate is legal only on a slow system clock; the
        // block cannot know the frequency and trusts software
        unitCtrl.securityRatio <= wbDatIn[1:0];
        unitCtrl.pciDmaEnable  <= wbDatIn[2];
        unitWritten            <= 1'b1;
      end else if (wbAdr == OFS_LB_CTRL) begin
        lbOutDiv <= wbDatIn[3:0];
      end
    end
  end

  // ==========================================================
  // unit clock generation
  // ==========================================================
  // security ratio code doubles as its divisor: off, 1, 2, 3
  assign secDivisor = (unitCtrl.securityRatio == SEC_OFF) ? DIV_OFF :
                      4'(unitCtrl.securityRatio);

  scd_clk_div #(.W(DIV_W)) uSecDiv (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .divisor (secDivisor),
    .tick    (securityClockEnable),
    .level   ()
  );

  scd_clk_div #(.W(DIV_W)) uPciDiv (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .divisor (unitCtrl.pciDmaEnable ? DIV_FULL : DIV_OFF),
    .tick    (pciDmaClockEnable),
    .level   ()
  );

  scd_clk_div #(.W(DIV_W)) uMemDiv (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .divisor (MEM_BUS_DIV),
    .tick    (),
    .level   (memctlOneBusClock)
  );

  scd_clk_div #(.W(DIV_W)) uLbDiv (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .divisor (lbOutDiv),
    .tick    (),
    .level   (lbLevel)
  );

  assign localBusClockOutputs = {3{lbLevel}};
  assign localBusSyncOutput   = lbLevel;

  // ==========================================================
  // assertions
  // ==========================================================
  chk_primary_select: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady |-> primaryFromPciSync ==
      (cfgHigh.hostModeSelect && !cfgHigh.pciClockOutputEnable))
    else $error("primary clock select disagrees with config");

  chk_sys_mult: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady |-> sysBusMult ==
      (6'(cfgLow.systemPllMultiplier) << clkinDivLatched))
    else $error("system bus multiple wrong");

  chk_core_mult: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady && ce |=> coreHalfMult ==
      11'($past(sysBusMult)) * 11'(cfgLow.corePllRatio[4:0]))
    else $error("core multiple not built on system clock");

  chk_eng_div: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady |-> engineDivide == (cfgLow.enginePllDivider ? 2'h2 : 2'h1))
    else $error("engine divide wrong");

  chk_eng_code_x16: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady && cfgLow.enginePllMultiplier == ENG_CODE_X16 |->
      engineMult == ENG_FACTOR_X16 && !engineCodeReserved)
    else $error("engine code zero must give sixteen");

  chk_eng_code_rsvd: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady && cfgLow.enginePllMultiplier == ENG_CODE_RSVD |->
      engineCodeReserved && engineMult == ENG_FACTOR_NONE)
    else $error("reserved engine code not flagged");

  chk_vco_mult: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady |-> engineVcoMult ==
      (10'(engineMult) << (3'(cfgLow.engineVcoDivider) + 3'h1)))
    else $error("engine vco multiple wrong");

  chk_mem_lb_mult: assert property (
    @(posedge clk) disable iff (!rst_b)
    configReady |->
      memctlOneMult == (7'(sysBusMult) << cfgLow.memctlOneClockRatio) &&
      localBusUnitMult == (7'(sysBusMult) << cfgLow.localBusClockRatio))
    else $error("memctl or local bus multiple wrong");

  chk_sec_default: assert property (
    @(posedge clk) disable iff (!rst_b)
    !unitWritten |-> unitCtrl.securityRatio == SEC_THIRD)
    else $error("security ratio left its default unwritten");

  chk_strap_latch: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && state == ST_SAMPLE && pinSync.hardResetInput_b |=>
      state == ST_RUN && !strapReceiverEnable &&
      clkinDivLatched == $past(pinSync.clkinDivider) &&
      cfgHigh == $past(pinSync.cfgHigh))
    else $error("straps not latched at hard reset release");

endmodule
`default_nettype wire

// ---- test/scd_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// board side: hard reset source and strap resistors
module scd_board_model (
  input  wire logic        clk,
  input  wire logic        holdReset,
  input  wire logic [31:0] lowWord,
  input  wire logic [31:0] highWord,
  input  wire logic        divStrap,
  input  wire logic [2:0]  srcSel,
  output logic             hardResetInput_b,
  output logic             clkinDividerPin,
  output logic [2:0]       resetSourcePin,
  output logic [31:0]      resetConfigWordLow,
  output logic [31:0]      resetConfigWordHigh
);
  logic [3:0] holdCnt; // straps stay put a while after release
  logic       drive;
  always_ff @(posedge clk) begin
    if (holdReset) begin
      holdCnt <= 4'h8;
    end else if (holdCnt != 4'h0) begin
      holdCnt <= holdCnt - 4'h1;
    end
  end
  assign drive = holdReset || (holdCnt != 4'h0);
  // after hold time the pins carry other traffic, shown inverted
  always_comb begin
    hardResetInput_b    = !holdReset;
    clkinDividerPin     = drive ? divStrap : !divStrap;
    resetSourcePin      = drive ? srcSel : ~srcSel;
    resetConfigWordLow  = drive ? lowWord : ~lowWord;
    resetConfigWordHigh = drive ? highWord : ~highWord;
  end
endmodule
`default_nettype wire

// ---- test/tb_system_clock_derivation.sv ----
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bench: strap capture, derived ratios, unit clock registers
module tb_system_clock_derivation
  import scd_pkg::*;
();
  logic        clk, rst_b, ce, wbCyc, wbStb, wbWe, hold, divS, wbAck;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatIn, wbDatOut, rd, lowW, highW;
  logic [31:0] resetConfigWordLow, resetConfigWordHigh;
  logic [2:0]  src, resetSourcePin, localBusClockOutputs;
  logic        hardResetInput_b, clkinDividerPin, strapReceiverEnable;
  logic        configReady, primaryFromPciSync, agentStrapFault;
  logic        engineCodeReserved, memctlOneBusClock, localBusSyncOutput;
  logic        securityClockEnable, pciDmaClockEnable;
  logic [5:0]  sysBusMult;
  logic [10:0] coreHalfMult;
  logic [4:0]  engineMult;
  logic [1:0]  engineDivide;
  logic [9:0]  engineVcoMult;
  logic [6:0]  memctlOneMult, localBusUnitMult;
  int          errCount = 0, checked = 0, p, k;
  scd_top DUT (.*);
  scd_board_model BRD (.clk(clk), .holdReset(hold), .lowWord(lowW),
    .highWord(highW), .divStrap(divS), .srcSel(src), .*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    if (errCount == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // wishbone classic cycle, bounded wait for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatIn} <= {2'b11, we, a, d};
    do begin @(posedge clk); n++; end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) errCount++;
    if (n >= 20) end_sim();
    rd = wbDatOut;
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clk);
  endtask
  // hard reset pulse with straps presented, wait for capture
  task automatic cfg(input logic [31:0] w, h, input logic d);
    int n = 0;
    @(posedge clk);
    {hold, lowW, highW, divS} <= {1'b1, w, h, d};
    repeat (6) @(posedge clk);
    hold <= 1'b0;
    do begin @(posedge clk); n++; end while (configReady !== 1'b1 && n < 20);
    if (n >= 20) errCount++;
    if (n >= 20) end_sim();
  endtask
  task automatic cfgChk(input logic [31:0] w, h, input logic d);
    logic [31:0] s;
    logic [31:0] e;
    cfg(w, h, d);
    repeat (12) @(posedge clk);
    s = w[27:24] * (d + 1);
    e = (w[4:0] == 5'h0) ? 32'h10 :
        (w[4:0] == 5'h1 || w[4:0] > 5'h1C) ? 0 : w[4:0];
    chk("sys", s, sysBusMult);
    chk("core", s * w[20:16], coreHalfMult);
    chk("eng", e, engineMult);
    chk("div", w[5] + 1, engineDivide);
    chk("vco", e * (2 << w[7:6]), engineVcoMult);
    chk("mem", s * (w[30] + 1), memctlOneMult);
    chk("lb", s * (w[31] + 1), localBusUnitMult);
    chk("mode", {h[31] & !h[30], !h[31] & d, e == 0},
      {primaryFromPciSync, agentStrapFault, engineCodeReserved});
    chk("rx", 2'b10, {configReady, strapReceiverEnable});
  endtask
  initial begin
    {rst_b, wbCyc, wbStb, wbWe, divS, wbAdr, wbDatIn, lowW, highW, src} = '0;
    {hold, ce, wbSel} = 6'h3F;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rxon", 1, strapReceiverEnable);
    cfgChk(32'h4404_0040, 32'h8000_0000, 1'b1);
    cfgChk(32'h8302_003C, 32'h0000_0000, 1'b1);
    cfgChk(32'h0101_0001, 32'h4000_0000, 1'b0);
    wb(1'b1, OFS_CFG_LOW, 32'h0);
    wb(1'b0, OFS_CFG_LOW, 32'h0);
    chk("cfglow", 32'h0101_0001, rd);
    src <= SRC_OPTION_A;
    cfg(32'h0, 32'h0, 1'b0);
    wb(1'b0, OFS_CFG_LOW, 32'h0);
    chk("option", OPT_WORD_A, rd);
    wb(1'b0, OFS_UNIT_CTRL, 32'h0);
    chk("unit", 32'h7, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", RD_UNMAPPED, rd);
    wb(1'b1, OFS_LB_CTRL, 32'h5);
    wb(1'b0, OFS_LB_CTRL, 32'h0);
    chk("lbdiv", 32'h5, rd);
    for (k = 3; k > 0; k--) begin
      wb(1'b1, OFS_UNIT_CTRL, k | 4);
      // the period running at the write still uses the old ratio,
      // so one whole period is skipped before measuring
      p = 0;
      while (securityClockEnable !== 1'b1 && p < 40) @(posedge clk) p++;
      repeat (2) begin
        p = 0;
        do begin
          @(posedge clk);
          p++;
        end while (securityClockEnable !== 1'b1 && p < 40);
      end
      chk("secper", k, p);
      if (p >= 40) end_sim();
    end
    wb(1'b1, OFS_UNIT_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    p = 0;
    repeat (8) @(posedge clk) p += {securityClockEnable, pciDmaClockEnable} !== 2'b00;
    chk("off", 0, p);
    wb(1'b1, OFS_UNIT_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk("pci", 1, pciDmaClockEnable);
    p = memctlOneBusClock;
    @(posedge clk);
    chk("mck", !p, memctlOneBusClock);
    // clock enable low must freeze the unit clocks
    ce <= 1'b0;
    @(posedge clk);
    p = memctlOneBusClock;
    repeat (3) @(posedge clk);
    chk("cefreeze", p, memctlOneBusClock);
    ce <= 1'b1;
    // divider 5 is high 3 of 5 cycles: 6 in any 10 in a row
    p = 0;
    repeat (10) @(posedge clk)
      p += {localBusSyncOutput, localBusClockOutputs} == 4'hF;
    chk("lbclk", 6, p);
    end_sim();
  end
endmodule
`default_nettype wire
